// [src/oep_ctrl.sv]
// Purpose: Output enables, power mode, test pin routing and slicer power-off
// Assumes: sys_clk is the line-locked clock; pins synchronous to it
// Notes: Both registers are write only; enables reach the pads combinationally
`timescale 1ns/10ps
`default_nettype none
`include "oep_consts.svh"

module oep_ctrl (
    input wire logic sys_clk, // Line-locked clock
    input wire logic nrst, // Asynchronous reset, active low
    input wire logic scl_in, // Serial bus clock
    input wire logic sda_in, // Serial bus data in
    output logic sda_out, // Serial bus data out, always low
    output logic sda_oe_n, // Low while pulling sda
    input wire logic ext_oe_n, // External output-enable pin, active low
    input wire logic jtag_tlr, // JTAG sits in Test-Logic-Reset
    output logic port_a_oe_n, // Video port A drive, active low
    output logic port_b_oe_n, // Video port B drive, active low
    output logic pixclk_oe_n, // Pixel clock drive, active low
    output logic ref_oe_n, // Reference and line clocks drive, active low
    output logic half_line_locked_clock, // Line-locked clock at half the clk_div_tick rate
    output logic test_pin_out, // TDO pin value
    output logic test_pin_oe_n, // TDO pin drive, active low
    output logic clk_div_tick, // Internal clock enable per power mode
    output logic slicer_reset, // Slicer off, registers held in reset
    output logic old_timing // Legacy output timing select
);

    // ----------------------------------------
    // State and wires
    // ----------------------------------------
    oep_pkg::oep_st_t cur_ff;
    oep_pkg::oep_st_t nxt_st;
    logic rx_done;
    logic [7:0] rx_addr;
    logic [7:0] rx_data;
    logic wr_out_en;
    logic wr_pwr_clk;
    logic ext_sel;
    logic ext_ok;
    logic run_ok;
    logic [3:0] group_on;

    // ----------------------------------------
    // Helper functions
    // ----------------------------------------
    // Power mode field of a power/clock value
    function automatic oep_pkg::oep_pmode_t pmode(input logic [7:0] pc);
        return oep_pkg::oep_pmode_t'(pc[`OEP_PC_MODE_HI:`OEP_PC_MODE_LO]);
    endfunction

    // Output groups may drive only in active mode
    function automatic logic is_active(input logic [7:0] pc);
        return pmode(pc) == oep_pkg::PM_ACTIVE;
    endfunction

    // Divider counter bits that must be zero for a tick
    function automatic logic [2:0] div_mask(input logic [7:0] pc);
        logic [2:0] m;
        case (pmode(pc))
            oep_pkg::PM_DIV2: begin
                m = 3'h1;
            end
            oep_pkg::PM_DIV4: begin
                m = 3'h3;
            end
            oep_pkg::PM_DIV8: begin
                m = 3'h7;
            end
            default: begin
                m = 3'h0;
            end
        endcase
        return m;
    endfunction

    // Clock enable for a mode and a divider count
    function automatic logic tick_for(
        input logic [7:0] pc,
        input logic [2:0] cnt
    );
        return is_active(pc) | ((cnt & div_mask(pc)) == 3'h0);
    endfunction

    // External enable level after the latch and delay options
    function automatic logic ext_level(
        input logic [7:0] oe,
        input logic raw,
        input logic s1,
        input logic s2
    );
        logic lvl;
        if (oe[`OEP_OE_LATCH]) begin
            if (oe[`OEP_OE_NODELAY]) begin
                lvl = s1;
            end else begin
                lvl = s2;
            end
        end else begin
            lvl = raw;
        end
        return lvl;
    endfunction

    // Test pin level: half clock with polarity, or the static bit
    function automatic logic pin_level(
        input logic [7:0] pc,
        input logic half
    );
        logic lvl;
        if (pc[`OEP_PC_PIN_SEL]) begin
            lvl = half ^ pc[`OEP_PC_POL];
        end else begin
            lvl = pc[`OEP_PC_POL];
        end
        return lvl;
    endfunction

    // ----------------------------------------
    // Serial slave
    // ----------------------------------------
    oep_serial_rx u_rx (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .soft_rst(cur_ff.bus_rst),
        .scl_in(scl_in),
        .sda_in(sda_in),
        .sda_oe_n(sda_oe_n),
        .wr_done(rx_done),
        .wr_addr(rx_addr),
        .wr_data(rx_data)
    );

    // ----------------------------------------
    // Register write decode
    // ----------------------------------------
    assign wr_out_en = rx_done & (rx_addr == `OEP_ADDR_OUT_EN);
    assign wr_pwr_clk = rx_done & (rx_addr == `OEP_ADDR_PWR_CLK);

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        nxt_st = cur_ff;
        if (wr_out_en) begin
            nxt_st.out_en = rx_data;
        end
        if (wr_pwr_clk) begin
            nxt_st.pwr_clk = rx_data & `OEP_PWR_CLK_WMASK;
        end
        // One-cycle pulse so the bus is not locked out afterwards
        nxt_st.bus_rst = wr_pwr_clk & rx_data[`OEP_PC_BUS_RST];
        nxt_st.oe_s1 = ext_oe_n;
        nxt_st.oe_s2 = cur_ff.oe_s1;
        nxt_st.div_cnt = cur_ff.div_cnt + 3'h1;
        // Tick follows the new mode so outputs and tick switch together
        nxt_st.div_tick = tick_for(nxt_st.pwr_clk, nxt_st.div_cnt);
        nxt_st.half_clk = cur_ff.half_clk ^ cur_ff.div_tick;
        nxt_st.test_val = pin_level(nxt_st.pwr_clk, nxt_st.half_clk);
    end

    // ----------------------------------------
    // State register
    // ----------------------------------------
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            cur_ff <= '{
                out_en: `OEP_OUT_EN_RST,
                pwr_clk: `OEP_PWR_CLK_RST,
                oe_s1: 1'b1,
                oe_s2: 1'b1,
                half_clk: 1'b0,
                div_cnt: 3'h0,
                div_tick: 1'b1,
                test_val: 1'b0,
                bus_rst: 1'b0
            };
        end else begin
            cur_ff <= nxt_st;
        end
    end

    // ----------------------------------------
    // External enable handling
    // ----------------------------------------
    assign ext_sel = ext_level(cur_ff.out_en, ext_oe_n, cur_ff.oe_s1, cur_ff.oe_s2);
    assign ext_ok = cur_ff.out_en[`OEP_OE_PIN_DIS] | ~ext_sel;
    assign run_ok = ext_ok & is_active(cur_ff.pwr_clk);

    // ----------------------------------------
    // Output group enables
    // ----------------------------------------
    assign group_on[0] = run_ok & cur_ff.out_en[`OEP_OE_PORT_A];
    assign group_on[1] = run_ok & cur_ff.out_en[`OEP_OE_PORT_B];
    assign group_on[2] = run_ok & cur_ff.out_en[`OEP_OE_PIXCLK];
    assign group_on[3] = run_ok & cur_ff.out_en[`OEP_OE_REF];
    assign port_a_oe_n = ~group_on[0];
    assign port_b_oe_n = ~group_on[1];
    assign pixclk_oe_n = ~group_on[2];
    assign ref_oe_n = ~group_on[3];

    // ----------------------------------------
    // Clocks, test pin and mode outputs
    // ----------------------------------------
    assign sda_out = 1'b0;
    assign half_line_locked_clock = cur_ff.half_clk;
    assign test_pin_out = cur_ff.test_val;
    assign test_pin_oe_n = ~(cur_ff.out_en[`OEP_OE_TESTPIN] & jtag_tlr);
    assign clk_div_tick = cur_ff.div_tick;
    assign slicer_reset = cur_ff.pwr_clk[`OEP_PC_SLICER_OFF];
    assign old_timing = cur_ff.pwr_clk[`OEP_PC_OLD_TIMING];

endmodule // oep_ctrl
`default_nettype wire

// [src/oep_consts.svh]
// Purpose: Constants for the output enable / power mode control block
// Assumes: Registers reached over the two-wire serial control bus
// Notes: Offsets are serial bus subaddresses
//
// Contract
// - Each output group drives only when enabled
// - Test pin clock only in reset state
// - Delay select passes or delays input
// - Latch select registers enable input
// - Bit 7 ignores external enable pin
// - Power mode: tri-state and divide clock
// - Bit 3 picks half clock or bit 4
// - Bit 4 sets half clock polarity
// - Bit 5 powers down, resets slicer
// - Select bit picks old or new timing
`ifndef OEP_CONSTS_SVH
`define OEP_CONSTS_SVH

// ----------------------------------------
// Register subaddresses
// ----------------------------------------
`define OEP_ADDR_OUT_EN 8'hf2
`define OEP_ADDR_PWR_CLK 8'haa

// ----------------------------------------
// Reset values and write masks
// ----------------------------------------
`define OEP_OUT_EN_RST 8'h00
`define OEP_PWR_CLK_RST 8'h00
`define OEP_PWR_CLK_WMASK 8'h7f

// ----------------------------------------
// output_drive_enable fields
// ----------------------------------------
`define OEP_OE_PORT_A 0
`define OEP_OE_PORT_B 1
`define OEP_OE_PIXCLK 2
`define OEP_OE_REF 3
`define OEP_OE_TESTPIN 4
`define OEP_OE_NODELAY 5
`define OEP_OE_LATCH 6
`define OEP_OE_PIN_DIS 7

// ----------------------------------------
// power_clock_mode_control fields
// ----------------------------------------
`define OEP_PC_MODE_LO 0
`define OEP_PC_MODE_HI 1
`define OEP_PC_BUS_RST 2
`define OEP_PC_PIN_SEL 3
`define OEP_PC_POL 4
`define OEP_PC_SLICER_OFF 5
`define OEP_PC_OLD_TIMING 6

// ----------------------------------------
// Serial slave
// ----------------------------------------
`define OEP_DEV_ADDR 7'h43
`define OEP_BITS_PER_BYTE 4'h8

`endif

// [src/oep_pkg.sv]
// Purpose: Types for the output enable / power mode control block
// Assumes: Nothing beyond the constants header
// Notes: States are Gray coded along the write path
package oep_pkg;

    typedef enum logic [2:0] {
        RX_IDLE = 3'h0,
        RX_ADDR = 3'h1,
        RX_ACK_A = 3'h3,
        RX_SUB = 3'h2,
        RX_ACK_S = 3'h6,
        RX_DATA = 3'h7,
        RX_ACK_D = 3'h5,
        RX_IGNORE = 3'h4
    } oep_rx_state_t;

    typedef enum logic [1:0] {
        PM_ACTIVE = 2'h0,
        PM_DIV2 = 2'h1,
        PM_DIV4 = 2'h2,
        PM_DIV8 = 2'h3
    } oep_pmode_t;

    typedef struct packed {
        oep_rx_state_t state;
        logic [3:0] cnt;
        logic [7:0] shift;
        logic [7:0] sub;
        logic [7:0] data;
        logic drive;
        logic done;
        logic scl_d;
        logic sda_d;
    } oep_rx_st_t;

    typedef struct packed {
        logic [7:0] out_en;
        logic [7:0] pwr_clk;
        logic oe_s1;
        logic oe_s2;
        logic half_clk;
        logic [2:0] div_cnt;
        logic div_tick;
        logic test_val;
        logic bus_rst;
    } oep_st_t;

endpackage

// [src/oep_serial_rx.sv]
// Purpose: Write-only two-wire serial slave: device address, subaddress, one data byte
// Assumes: scl and sda are synchronous to sys_clk and slow against it
// Notes: Further data bytes of one transfer are not acknowledged
`timescale 1ns/10ps
`default_nettype none
`include "oep_consts.svh"

module oep_serial_rx (
    input wire logic sys_clk, // Block clock
    input wire logic nrst, // Asynchronous reset, active low
    input wire logic soft_rst, // Synchronous interface reset
    input wire logic scl_in, // Serial clock level
    input wire logic sda_in, // Serial data level
    output logic sda_oe_n, // Low while pulling sda low
    output logic wr_done, // One-cycle pulse, byte written
    output logic [7:0] wr_addr, // Subaddress of written byte
    output logic [7:0] wr_data // Written byte
);

    oep_pkg::oep_rx_st_t cur_ff;
    oep_pkg::oep_rx_st_t nxt_st;
    logic scl_rise;
    logic scl_fall;
    logic start_cond;
    logic stop_cond;

    assign scl_rise = scl_in & ~cur_ff.scl_d;
    assign scl_fall = ~scl_in & cur_ff.scl_d;
    assign start_cond = scl_in & cur_ff.scl_d & cur_ff.sda_d & ~sda_in;
    assign stop_cond = scl_in & cur_ff.scl_d & ~cur_ff.sda_d & sda_in;

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        nxt_st = cur_ff;
        nxt_st.scl_d = scl_in;
        nxt_st.sda_d = sda_in;
        nxt_st.done = 1'b0;
        if (soft_rst) begin
            nxt_st.state = oep_pkg::RX_IDLE;
            nxt_st.drive = 1'b0;
            nxt_st.cnt = 4'h0;
        end else if (start_cond) begin
            nxt_st.state = oep_pkg::RX_ADDR;
            nxt_st.cnt = 4'h0;
            nxt_st.drive = 1'b0;
        end else if (stop_cond) begin
            nxt_st.state = oep_pkg::RX_IDLE;
            nxt_st.drive = 1'b0;
        end else begin
            case (cur_ff.state)
                oep_pkg::RX_ADDR, oep_pkg::RX_SUB, oep_pkg::RX_DATA: begin
                    if (scl_rise) begin
                        nxt_st.shift = {cur_ff.shift[6:0], sda_in};
                        nxt_st.cnt = cur_ff.cnt + 4'h1;
                    end else if (scl_fall && cur_ff.cnt == `OEP_BITS_PER_BYTE) begin
                        nxt_st.cnt = 4'h0;
                        nxt_st.drive = 1'b1;
                        if (cur_ff.state == oep_pkg::RX_ADDR) begin
                            if (cur_ff.shift == {`OEP_DEV_ADDR, 1'b0}) begin
                                nxt_st.state = oep_pkg::RX_ACK_A;
                            end else begin
                                nxt_st.state = oep_pkg::RX_IGNORE;
                                nxt_st.drive = 1'b0;
                            end
                        end else if (cur_ff.state == oep_pkg::RX_SUB) begin
                            nxt_st.sub = cur_ff.shift;
                            nxt_st.state = oep_pkg::RX_ACK_S;
                        end else begin
                            nxt_st.data = cur_ff.shift;
                            nxt_st.state = oep_pkg::RX_ACK_D;
                        end
                    end
                end
                oep_pkg::RX_ACK_A: begin
                    if (scl_fall) begin
                        nxt_st.drive = 1'b0;
                        nxt_st.state = oep_pkg::RX_SUB;
                    end
                end
                oep_pkg::RX_ACK_S: begin
                    if (scl_fall) begin
                        nxt_st.drive = 1'b0;
                        nxt_st.state = oep_pkg::RX_DATA;
                    end
                end
                oep_pkg::RX_ACK_D: begin
                    if (scl_fall) begin
                        nxt_st.drive = 1'b0;
                        nxt_st.done = 1'b1;
                        nxt_st.state = oep_pkg::RX_IGNORE;
                    end
                end
                oep_pkg::RX_IDLE, oep_pkg::RX_IGNORE: begin
                    nxt_st.drive = 1'b0;
                end
                default: begin
                    nxt_st.state = oep_pkg::RX_IDLE;
                    nxt_st.drive = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            cur_ff <= '{state: oep_pkg::RX_IDLE, cnt: 4'h0, shift: 8'h00, sub: 8'h00,
                        data: 8'h00, drive: 1'b0, done: 1'b0, scl_d: 1'b1, sda_d: 1'b1};
        end else begin
            cur_ff <= nxt_st;
        end
    end

    assign sda_oe_n = ~cur_ff.drive;
    assign wr_done = cur_ff.done;
    assign wr_addr = cur_ff.sub;
    assign wr_data = cur_ff.data;

endmodule // oep_serial_rx
`default_nettype wire

// [sim/oep_ctrl_properties.sv]
// Purpose: Port checks for oep_ctrl
// Assumes: Enables reach pads combinationally
// Notes: Bound from tb_top
`timescale 1ns/10ps
`default_nettype none
module oep_ctrl_properties (
    input wire logic sys_clk, // Clock
    input wire logic nrst, // Reset
    input wire logic scl_in, // Bus clock
    input wire logic sda_out, // Bus data
    input wire logic sda_oe_n, // Bus drive
    input wire logic jtag_tlr, // Tap reset
    input wire logic port_a_oe_n, // Port A
    input wire logic port_b_oe_n, // Port B
    input wire logic pixclk_oe_n, // Pixclk
    input wire logic ref_oe_n, // Refs
    input wire logic half_line_locked_clock, // Half clock
    input wire logic test_pin_oe_n, // Pin drive
    input wire logic clk_div_tick, // Clock enable
    input wire logic slicer_reset, // Slicer off
    input wire logic old_timing // Timing
);
    logic [5:0] idle_ff;
    logic [5:0] nxt_idle;
    logic all_off;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    assign all_off = port_a_oe_n & port_b_oe_n & pixclk_oe_n & ref_oe_n;
    // Cycles since the bus clock was last low
    assign nxt_idle = !scl_in ? 6'h0 : idle_ff + {5'h0, idle_ff != 6'h3f};
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) idle_ff <= 6'h0;
        else idle_ff <= nxt_idle;
    end
    a_tdo_tlr_only: assert property (!jtag_tlr |-> test_pin_oe_n)
        else $error("test pin driven");
    a_sda_pull_low: assert property (!sda_oe_n |-> !sda_out)
        else $error("sda high");
    a_half_clk_run: assert property (clk_div_tick |=> $changed(half_line_locked_clock))
        else $error("half clock stuck");
    a_lowpow_hiz: assert property (!clk_div_tick |-> all_off)
        else $error("drive in low power");
    a_div_gap_max: assert property (!clk_div_tick [*7] |=> clk_div_tick)
        else $error("tick gap");
    a_reset_hiz: assert property (disable iff (1'b0) !nrst |-> all_off)
        else $error("drive in reset");
    a_slicer_on_write: assert property ($changed(slicer_reset) |-> idle_ff < 6'h28)
        else $error("slicer change");
    a_timing_on_write: assert property ($changed(old_timing) |-> idle_ff < 6'h28)
        else $error("timing change");
endmodule // oep_ctrl_properties
`default_nettype wire

// [sim/oep_host.sv]
// Purpose: Serial bus host
// Assumes: Bus slow against sys_clk
// Notes: Acknowledge bits clocked only
`timescale 1ns/10ps
`default_nettype none
`include "oep_consts.svh"
module oep_host (
    input wire logic sys_clk, // Clock
    output var logic scl, // Bus clock
    output var logic sda // Data, 1 releases
);
    initial begin
        scl = 1'b1;
        sda = 1'b1;
    end
    task automatic step(input logic c, input logic d);
        repeat (4) @(posedge sys_clk);
        #1 scl = c;
        repeat (2) @(posedge sys_clk);
        #1 sda = d;
    endtask
    task automatic send(input logic [7:0] v);
        for (int i = 7; i >= 0; i--) begin
            step(1'b0, v[i]);
            step(1'b1, v[i]);
        end
        step(1'b0, 1'b1);
        step(1'b1, 1'b1);
    endtask
    task automatic write(input logic [7:0] a, input logic [7:0] d);
        step(1'b1, 1'b0);
        send({`OEP_DEV_ADDR, 1'b0});
        send(a);
        send(d & (a == `OEP_ADDR_PWR_CLK ? `OEP_PWR_CLK_WMASK : 8'hff));
        step(1'b0, 1'b0);
        step(1'b1, 1'b0);
        step(1'b1, 1'b1);
    endtask
endmodule // oep_host
`default_nettype wire

// [sim/tb_top.sv]
// Purpose: Bench for oep_ctrl
// Assumes: Writes settle in 20 cycles
// Notes: Register writes only
`timescale 1ns/10ps
`default_nettype none
`include "oep_consts.svh"
module tb_top;
    logic sys_clk = 1'b0;
    logic nrst = 1'b0;
    logic ext_oe_n = 1'b0;
    logic jtag_tlr = 1'b1;
    logic scl, sda_h, sda_oe_n, hc, tp, tpo, tick, sr, ot;
    logic [3:0] en;
    wire logic sda = sda_h & sda_oe_n;
    int n_errors = 0;
    int compares = 0;
    int ticks;
    oep_host u_host (.sys_clk(sys_clk), .scl(scl), .sda(sda_h));
    oep_ctrl DUT (.sys_clk(sys_clk), .nrst(nrst), .scl_in(scl), .sda_in(sda), .sda_out(),
        .sda_oe_n(sda_oe_n), .ext_oe_n(ext_oe_n), .jtag_tlr(jtag_tlr), .port_a_oe_n(en[0]),
        .port_b_oe_n(en[1]), .pixclk_oe_n(en[2]), .ref_oe_n(en[3]),
        .half_line_locked_clock(hc), .test_pin_out(tp), .test_pin_oe_n(tpo),
        .clk_div_tick(tick), .slicer_reset(sr), .old_timing(ot));
    initial forever #10 sys_clk = ~sys_clk;
    task automatic check(input string s, input logic [7:0] e, input logic [7:0] g);
        compares++;
        if (g !== e) begin
            n_errors++;
            $display("unexpected %s: expected %h seen %h", s, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        u_host.write(a, d);
        repeat (20) @(posedge sys_clk);
        #1;
    endtask
    // Enables before and zero, one, two cycles after the pin goes inactive
    task automatic oe_seq(input logic [7:0] cfg, input logic [15:0] e);
        wr(`OEP_ADDR_OUT_EN, cfg);
        check("enables", e[15:12], en);
        @(posedge sys_clk);
        #1 ext_oe_n = 1'b1;
        #1 check("oe now", e[11:8], en);
        @(posedge sys_clk);
        #1 check("oe one", e[7:4], en);
        @(posedge sys_clk);
        #1 check("oe two", e[3:0], en);
        ext_oe_n = 1'b0;
    endtask
    task automatic conclude;
        if (n_errors == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    initial begin
        #1000000;
        n_errors++;
        conclude();
    end
    initial begin
        repeat (3) @(posedge sys_clk);
        #1 nrst = 1'b1;
        oe_seq(8'h0f, 16'h0fff);
        oe_seq(8'h4f, 16'h000f);
        oe_seq(8'h6f, 16'h00ff);
        oe_seq(8'h8f, 16'h0000);
        oe_seq(8'h0a, 16'h5fff);
        wr(`OEP_ADDR_OUT_EN, 8'h9f);
        for (int m = 1; m < 4; m++) begin
            wr(`OEP_ADDR_PWR_CLK, 8'(m));
            check("low power", 4'hf, en);
            ticks = 0;
            repeat (64) begin
                @(posedge sys_clk);
                #1 ticks += int'(tick);
            end
            check("ticks", 8'(64 >> m), 8'(ticks));
        end
        wr(`OEP_ADDR_PWR_CLK, 8'h10);
        check("active", 4'h0, en);
        check("pin", 2'h2, {tp, tpo});
        jtag_tlr = 1'b0;
        #1 check("pin off", 1'h1, tpo);
        @(posedge sys_clk);
        #1 jtag_tlr = 1'b1;
        for (int p = 0; p < 2; p++) begin
            wr(`OEP_ADDR_PWR_CLK, {3'h0, p[0], 4'h8});
            check("pin clock", {p[0], 1'h0}, {tp ^ hc, tpo});
        end
        wr(`OEP_ADDR_PWR_CLK, 8'h20);
        check("slicer", 2'h2, {sr, ot});
        wr(`OEP_ADDR_PWR_CLK, 8'h40);
        check("timing", 2'h1, {sr, ot});
        conclude();
    end
endmodule // tb_top
bind oep_ctrl oep_ctrl_properties u_props (.*);
`default_nettype wire
